// ===== assi_pkg.sv
/*
 * Shared constants and carriers for the converter's serial/sync interface.
 * Assumes a 200 MHz main clock and a serial clock from the host controller.
 */
package assi_pkg;

    // main clock period in picoseconds (200 MHz)
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // serial word layout
    localparam int unsigned WORD_W = 24;
    localparam int unsigned FRAME_WORDS_DEF = 2;

    // combined sync/reset pin, in main-clock periods
    localparam int unsigned SYNC_MIN_CYC = 1;
    localparam int unsigned SYNC_MAX_CYC = 2047;
    localparam int unsigned RESET_MIN_CYC = 2048;

    // data-ready pulse phases, in main-clock periods
    localparam int unsigned READY_HIGH_CYC = 4;
    localparam int unsigned READY_LOW_CYC = 4;

    // serial frame abandon time, in main-clock periods
    localparam int unsigned SPI_TIMEOUT_CYC = 32768;

    // power-on time to first data-ready, and register load time
    localparam int unsigned POR_TIME_US = 250;
    localparam int unsigned POR_CYC =
        (POR_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REGACQ_TIME_US = 5;
    localparam int unsigned REGACQ_CYC =
        (REGACQ_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // synchroniser lanes: serial word toggle, chip select, sync pin
    localparam int unsigned LANE_TOG = 0;
    localparam int unsigned LANE_CS = 1;
    localparam int unsigned LANE_SYN = 2;
    localparam logic [2:0] LANE_RST = 3'h6;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] data;
    } assi_rx_s;

    typedef struct packed {
        logic por_done;
        logic regs_ready;
        logic sync_pulse;
        logic dev_reset;
        logic frame_abort;
    } assi_stat_s;

endpackage : assi_pkg

// ===== assi_link.sv
/*
 * Serial-clock domain of the interface: input capture and output shift.
 * Assumes the host keeps the serial clock low while chip select changes.
 */
`timescale 1ns/1ps

module assi_link
(
    input wire logic i_sclk,                        // serial clock
    input wire logic i_cs_n,                        // chip select, low active
    input wire logic i_abort,                       // frame abandoned
    input wire logic i_reset_n,                     // device reset
    input wire logic i_din,                         // serial data in
    input wire logic [assi_pkg::WORD_W-1:0] i_tx_word, // held word to send
    output logic o_dout,                            // serial data out
    output logic [assi_pkg::WORD_W-1:0] o_rx_word,  // last whole word
    output logic o_word_tog                         // flips per whole word
);

    localparam int unsigned CNT_W = $clog2(assi_pkg::WORD_W);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(assi_pkg::WORD_W - 1);

    logic frame_rst_n;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [assi_pkg::WORD_W-1:0] rx_sh_ff;
    logic [assi_pkg::WORD_W-1:0] tx_sh_ff;
    logic [assi_pkg::WORD_W-1:0] rx_word_ff;
    logic tog_ff;
    logic dout_ff;

    // frame state ends with the frame itself, since the clock may stop
    assign frame_rst_n = i_reset_n & ~i_cs_n & ~i_abort;

    ////////////////////////////////////////////////////////////////////////
    // capture on the trailing (falling) edge
    always_ff @(negedge i_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_cnt_ff <= '0;
            rx_sh_ff <= '0;
        end
        else
        begin
            rx_sh_ff <= {rx_sh_ff[assi_pkg::WORD_W-2:0], i_din};
            bit_cnt_ff <= (bit_cnt_ff == LAST_BIT) ? '0 : bit_cnt_ff + 1'b1;
        end
    end

    // word result and toggle survive the frame end for the main domain
    always_ff @(negedge i_sclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rx_word_ff <= '0;
            tog_ff <= 1'b0;
        end
        else if (frame_rst_n && bit_cnt_ff == LAST_BIT)
        begin
            rx_word_ff <= {rx_sh_ff[assi_pkg::WORD_W-2:0], i_din};
            tog_ff <= ~tog_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // launch after each rising edge, msb first
    always_ff @(posedge i_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            tx_sh_ff <= '0;
            dout_ff <= 1'b0;
        end
        else if (bit_cnt_ff == '0)
        begin
            dout_ff <= i_tx_word[assi_pkg::WORD_W-1];
            tx_sh_ff <= {i_tx_word[assi_pkg::WORD_W-2:0], 1'b0};
        end
        else
        begin
            dout_ff <= tx_sh_ff[assi_pkg::WORD_W-1];
            tx_sh_ff <= {tx_sh_ff[assi_pkg::WORD_W-2:0], 1'b0};
        end
    end

    assign o_dout = dout_ff;
    assign o_rx_word = rx_word_ff;
    assign o_word_tog = tog_ff;

endmodule : assi_link

// ===== assi_core.sv
/*
 * Digital interface of a two-channel converter: serial port, combined
 * sync/reset pin, data-ready pulse, power-on and register-load latencies.
 * Assumes a free-running 200 MHz main clock and a host serial controller.
 */
// What this block does
// - short sync-pin low pulse means synchronize
// - low for 2048 periods resets device
// - sync pin sampled on main clock edges
// - data-ready high phase lasts four periods
// - data-ready low phase lasts four periods
// - serial mode: clock idles low, trailing capture
// - input bits captured on falling serial edge
// - output bits launched after rising serial edge
// - output driven once chip select goes low
// - output released after chip select rises
// - first data-ready about 250 us after power
// - registers usable 5 us after reset
`timescale 1ns/1ps

module assi_core
#(
    parameter int unsigned FRAME_WORDS = assi_pkg::FRAME_WORDS_DEF,
    parameter int unsigned POR_CYC = assi_pkg::POR_CYC,
    parameter int unsigned TIMEOUT_CYC = assi_pkg::SPI_TIMEOUT_CYC
)
(
    input wire logic i_mclk,                        // main clock
    input wire logic i_reset_n,                     // async reset, low
    input wire logic i_sync_reset_n,                // sync/reset pin
    input wire logic i_sclk,                        // serial clock pin
    input wire logic i_cs_n,                        // chip select pin
    input wire logic i_din,                         // serial data in pin
    input wire logic i_sample_valid,                // new conversion result
    input wire logic [assi_pkg::WORD_W-1:0] i_tx_word, // word to send
    output logic o_dout,                            // serial data out
    output logic o_dout_oe,                         // data out drive enable
    output logic o_sample_ready_flag,               // data-ready pin
    output assi_pkg::assi_rx_s o_rx,                // received word
    output assi_pkg::assi_stat_s o_stat             // status pulses/levels
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks

    if (FRAME_WORDS < 1 || POR_CYC < 1 || TIMEOUT_CYC < 1)
    begin : g_bad_param
        $error("assi_core: counts must be at least one");
    end

    localparam int unsigned SYN_W = $clog2(assi_pkg::RESET_MIN_CYC + 1);
    localparam int unsigned TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam int unsigned POR_W = $clog2(POR_CYC + 1);
    localparam int unsigned ACQ_W = $clog2(assi_pkg::REGACQ_CYC + 1);
    localparam int unsigned WRD_W = $clog2(FRAME_WORDS + 1);
    localparam logic [SYN_W-1:0] SYN_MIN = SYN_W'(assi_pkg::SYNC_MIN_CYC);
    localparam logic [SYN_W-1:0] SYN_MAX = SYN_W'(assi_pkg::SYNC_MAX_CYC);
    localparam logic [SYN_W-1:0] RST_LEN = SYN_W'(assi_pkg::RESET_MIN_CYC);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYC - 1);
    localparam logic [ACQ_W-1:0] ACQ_LAST =
        ACQ_W'(assi_pkg::REGACQ_CYC - 1);
    localparam logic [WRD_W-1:0] WRD_FULL = WRD_W'(FRAME_WORDS);
    localparam logic [1:0] HI_LAST = 2'(assi_pkg::READY_HIGH_CYC - 1);
    localparam logic [1:0] LO_LAST = 2'(assi_pkg::READY_LOW_CYC - 1);

    typedef enum logic [1:0] {RDY_IDLE, RDY_HIGH, RDY_LOW} assi_rdy_e;

    logic [2:0] lane_in;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] lvl_ff;
    logic [2:0] lvl_prev_ff;
    logic tog_evt;
    logic cs_low;
    logic syn_low;
    logic syn_rise;

    logic link_tog;
    logic link_dout;
    logic [assi_pkg::WORD_W-1:0] link_rx;
    logic [assi_pkg::WORD_W-1:0] tx_hold_ff;

    logic [SYN_W-1:0] syn_len_ff;
    logic soft_rst;
    logic [TO_W-1:0] to_cnt_ff;
    logic abort_ff;
    logic [WRD_W-1:0] words_ff;
    logic [POR_W-1:0] por_cnt_ff;
    logic por_done_ff;
    logic [ACQ_W-1:0] acq_cnt_ff;
    logic acq_busy_ff;
    logic pend_ff;
    assi_rdy_e rdy_ff;
    logic [1:0] ph_cnt_ff;
    logic flag_ff;
    logic oe_ff;
    assi_pkg::assi_rx_s rx_ff;
    assi_pkg::assi_stat_s stat_ff;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree, except on the sync lane

    assign lane_in = {i_sync_reset_n, i_cs_n, link_tog};

    for (genvar g = 0; g < 3; g++)
    begin : g_lane
        always_ff @(posedge i_mclk or negedge i_reset_n)
        begin
            if (!i_reset_n)
            begin
                s1_ff[g] <= assi_pkg::LANE_RST[g];
                s2_ff[g] <= assi_pkg::LANE_RST[g];
                s3_ff[g] <= assi_pkg::LANE_RST[g];
                lvl_ff[g] <= assi_pkg::LANE_RST[g];
                lvl_prev_ff[g] <= assi_pkg::LANE_RST[g];
            end
            else
            begin
                s1_ff[g] <= lane_in[g];
                s2_ff[g] <= s1_ff[g];
                s3_ff[g] <= s2_ff[g];
                // sync lane takes every sample: one period low is a sync
                if (s2_ff[g] == s3_ff[g] || g == assi_pkg::LANE_SYN)
                begin
                    lvl_ff[g] <= s3_ff[g];
                end
                lvl_prev_ff[g] <= lvl_ff[g];
            end
        end
    end

    assign tog_evt = lvl_ff[assi_pkg::LANE_TOG]
                   ^ lvl_prev_ff[assi_pkg::LANE_TOG];
    assign cs_low = ~lvl_ff[assi_pkg::LANE_CS];
    assign syn_low = ~lvl_ff[assi_pkg::LANE_SYN];
    assign syn_rise = lvl_ff[assi_pkg::LANE_SYN]
                    & ~lvl_prev_ff[assi_pkg::LANE_SYN];

    ////////////////////////////////////////////////////////////////////////
    // serial clock domain

    assi_link u_link
    (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_abort(abort_ff),
        .i_reset_n(i_reset_n),
        .i_din(i_din),
        .i_tx_word(tx_hold_ff),
        .o_dout(link_dout),
        .o_rx_word(link_rx),
        .o_word_tog(link_tog)
    );

    // send word is frozen for the whole frame, so the link may read it
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tx_hold_ff <= '0;
        end
        else if (!cs_low && s2_ff[assi_pkg::LANE_CS]
                 && s3_ff[assi_pkg::LANE_CS])
        begin
            tx_hold_ff <= i_tx_word;
        end
    end

    // drive follows synced select: about 20 to 25 ns late on both edges
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            oe_ff <= 1'b0;
        end
        else
        begin
            oe_ff <= cs_low & ~abort_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received words and frame progress

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rx_ff <= '0;
        end
        else
        begin
            rx_ff.valid <= tog_evt & ~abort_ff;
            if (tog_evt)
            begin
                rx_ff.data <= link_rx;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            words_ff <= '0;
        end
        else if (!cs_low)
        begin
            words_ff <= '0;
        end
        else if (tog_evt && words_ff != WRD_FULL)
        begin
            words_ff <= words_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stalled frame timeout; abort holds until select is released

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            to_cnt_ff <= '0;
            abort_ff <= 1'b0;
        end
        else if (!cs_low)
        begin
            to_cnt_ff <= '0;
            abort_ff <= 1'b0;
        end
        else if (soft_rst)
        begin
            to_cnt_ff <= '0;
            abort_ff <= 1'b1;
        end
        else if (!abort_ff && words_ff != WRD_FULL)
        begin
            if (to_cnt_ff == TO_LAST)
            begin
                abort_ff <= 1'b1;
            end
            else
            begin
                to_cnt_ff <= to_cnt_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // combined sync/reset pin: length of the low phase decides

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            syn_len_ff <= '0;
        end
        else if (syn_low)
        begin
            if (syn_len_ff != RST_LEN)
            begin
                syn_len_ff <= syn_len_ff + 1'b1;
            end
        end
        else
        begin
            syn_len_ff <= '0;
        end
    end

    assign soft_rst = syn_low && syn_len_ff == RST_LEN - 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // power-on and register load latencies

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            por_cnt_ff <= '0;
            por_done_ff <= 1'b0;
        end
        else if (!por_done_ff)
        begin
            if (por_cnt_ff == POR_LAST)
            begin
                por_done_ff <= 1'b1;
            end
            else
            begin
                por_cnt_ff <= por_cnt_ff + 1'b1;
            end
        end
    end

    // restarts on each pin reset; nothing else waits on the register file
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            acq_cnt_ff <= '0;
            acq_busy_ff <= 1'b1;
        end
        else if (soft_rst)
        begin
            acq_cnt_ff <= '0;
            acq_busy_ff <= 1'b1;
        end
        else if (acq_busy_ff)
        begin
            if (acq_cnt_ff == ACQ_LAST)
            begin
                acq_busy_ff <= 1'b0;
            end
            else
            begin
                acq_cnt_ff <= acq_cnt_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data-ready pulse: high phase, then a guaranteed low phase

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pend_ff <= 1'b0;
        end
        else if (i_sample_valid || (por_done_ff && por_cnt_ff == POR_LAST
                 && !stat_ff.por_done))
        begin
            pend_ff <= 1'b1;
        end
        else if (soft_rst || (por_done_ff && (rdy_ff == RDY_IDLE
                 || (rdy_ff == RDY_LOW && ph_cnt_ff == LO_LAST))))
        begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdy_ff <= RDY_IDLE;
            ph_cnt_ff <= '0;
            flag_ff <= 1'b0;
        end
        else if (soft_rst)
        begin
            rdy_ff <= RDY_IDLE;
            ph_cnt_ff <= '0;
            flag_ff <= 1'b0;
        end
        else
        begin
            case (rdy_ff)
                RDY_IDLE:
                begin
                    if (pend_ff && por_done_ff)
                    begin
                        rdy_ff <= RDY_HIGH;
                        ph_cnt_ff <= '0;
                        flag_ff <= 1'b1;
                    end
                end
                RDY_HIGH:
                begin
                    if (ph_cnt_ff == HI_LAST)
                    begin
                        rdy_ff <= RDY_LOW;
                        ph_cnt_ff <= '0;
                        flag_ff <= 1'b0;
                    end
                    else
                    begin
                        ph_cnt_ff <= ph_cnt_ff + 1'b1;
                    end
                end
                RDY_LOW:
                begin
                    if (ph_cnt_ff == LO_LAST)
                    begin
                        // waiting event starts at once: low stays four
                        rdy_ff <= pend_ff ? RDY_HIGH : RDY_IDLE;
                        ph_cnt_ff <= '0;
                        flag_ff <= pend_ff;
                    end
                    else
                    begin
                        ph_cnt_ff <= ph_cnt_ff + 1'b1;
                    end
                end
                default:
                begin
                    rdy_ff <= RDY_IDLE;
                    ph_cnt_ff <= '0;
                    flag_ff <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            stat_ff <= '0;
        end
        else
        begin
            stat_ff.por_done <= por_done_ff;
            stat_ff.regs_ready <= ~acq_busy_ff & ~soft_rst;
            stat_ff.sync_pulse <= syn_rise && syn_len_ff >= SYN_MIN
                                  && syn_len_ff <= SYN_MAX;
            stat_ff.dev_reset <= soft_rst;
            stat_ff.frame_abort <= cs_low && !abort_ff && !soft_rst
                                   && words_ff != WRD_FULL
                                   && to_cnt_ff == TO_LAST;
        end
    end

    assign o_dout = link_dout;
    assign o_dout_oe = oe_ff;
    assign o_sample_ready_flag = flag_ff;
    assign o_rx = rx_ff;
    assign o_stat = stat_ff;

endmodule : assi_core

// ===== assi_host_model.sv
/* Host controller model: drives chip select, serial clock and data in.
   Assumes the device shifts out on rising and captures on falling edges. */
`timescale 1ns/1ps

module assi_host_model
(
    input wire logic i_dout,     // device serial out
    output logic o_sclk,         // serial clock, still between frames
    output logic o_cs_n,         // chip select, low active
    output logic o_din           // serial data to the device
);
    logic [47:0] rx_bits;

    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b1;
        rx_bits = 48'h0;
    end

    // odd offset keeps serial edges off the main clock grid
    task automatic frame(input int nbits, input logic [47:0] w,
                         input int hold);
        #3;
        o_cs_n = 1'b0;
        #40;
        for (int i = 0; i < nbits; i++)
        begin
            o_sclk = 1'b1;
            o_din = w[47-i];
            #40;
            o_sclk = 1'b0;
            rx_bits = {rx_bits[46:0], i_dout};
            #40;
        end
        #(hold);
        o_cs_n = 1'b1;
        // a released line must not look like held data
        o_din = ~o_din;
        #40;
    endtask : frame
endmodule : assi_host_model

// ===== assi_core_asserts.sv
/* Port-level checks of the converter interface.
   Bound into assi_core; sees only its ports. */
`timescale 1ns/1ps

module assi_core_chk
#(
    parameter int unsigned POR_CYC = 20,
    parameter int unsigned TIMEOUT_CYC = 1024
)
(
    input wire logic i_mclk,                // main clock
    input wire logic i_reset_n,             // async reset
    input wire logic i_sync_reset_n,        // sync/reset pin
    input wire logic i_cs_n,                // chip select
    input wire logic o_dout_oe,             // drive enable
    input wire logic o_sample_ready_flag,   // data-ready pin
    input wire assi_pkg::assi_stat_s o_stat // status
);
    logic [11:0] low_cnt_ff;
    logic [11:0] last_len_ff;
    logic [10:0] since_rst_ff;
    logic [15:0] cs_cnt_ff;
    logic [15:0] por_cnt_ff;

    ////////////////////////////////////////////////////////////
    // saturating counters, so long runs cannot wrap
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            low_cnt_ff <= 12'h000;
            last_len_ff <= 12'h000;
            since_rst_ff <= 11'h000;
            cs_cnt_ff <= 16'h0000;
            por_cnt_ff <= 16'h0000;
        end
        else
        begin
            low_cnt_ff <= i_sync_reset_n ? 12'h000 :
                low_cnt_ff + {11'h000, low_cnt_ff != 12'hFFF};
            if (i_sync_reset_n && low_cnt_ff != 12'h000)
                last_len_ff <= low_cnt_ff;
            since_rst_ff <= o_stat.dev_reset ? 11'h000 :
                since_rst_ff + {10'h000, since_rst_ff != 11'h7FF};
            cs_cnt_ff <= i_cs_n ? 16'h0000 :
                cs_cnt_ff + {15'h0000, cs_cnt_ff != 16'hFFFF};
            por_cnt_ff <= por_cnt_ff + {15'h0000, por_cnt_ff != 16'hFFFF};
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    ready_high_a: assert property ($rose(o_sample_ready_flag) |->
        o_sample_ready_flag[*4] ##1 !o_sample_ready_flag)
        else $error("ready high phase wrong");
    ready_low_a: assert property ($fell(o_sample_ready_flag) |->
        !o_sample_ready_flag[*4]) else $error("ready low phase short");
    sync_len_a: assert property (o_stat.sync_pulse |-> i_sync_reset_n &&
        last_len_ff >= 12'h001 && last_len_ff <= 12'h7FF)
        else $error("sync pulse for wrong low length");
    reset_len_a: assert property (o_stat.dev_reset |->
        (low_cnt_ff >= 12'h800 && low_cnt_ff <= 12'h808) ||
        (i_sync_reset_n && last_len_ff >= 12'h800))
        else $error("device reset for short low");
    regs_wait_a: assert property (o_stat.regs_ready |->
        since_rst_ff >= 11'h3E3) else $error("registers ready too early");
    por_wait_a: assert property (o_stat.por_done |->
        por_cnt_ff >= POR_CYC - 1) else $error("power-on done too early");
    first_ready_a: assert property ($rose(o_sample_ready_flag) |->
        o_stat.por_done) else $error("ready before power-on done");
    oe_drive_a: assert property ($fell(i_cs_n) |-> ##[1:10] o_dout_oe)
        else $error("data out not driven in time");
    oe_release_a: assert property ($rose(i_cs_n) |->
        ##[1:15] !o_dout_oe) else $error("data out not released in time");
    abort_wait_a: assert property (o_stat.frame_abort |->
        cs_cnt_ff >= TIMEOUT_CYC) else $error("frame abandoned too early");

    cover property (o_stat.sync_pulse);
    cover property (o_stat.dev_reset);
    cover property (o_stat.frame_abort);
    cover property ($rose(o_sample_ready_flag));
endmodule : assi_core_chk

bind assi_core assi_core_chk #(.POR_CYC(POR_CYC), .TIMEOUT_CYC(TIMEOUT_CYC))
    i_assi_core_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_sync_reset_n(i_sync_reset_n), .i_cs_n(i_cs_n),
    .o_dout_oe(o_dout_oe), .o_sample_ready_flag(o_sample_ready_flag),
    .o_stat(o_stat));

// ===== tb_top.sv
/* Self-checking bench for assi_core with a host controller model.
   Assumes short power-on and timeout counts set by parameter. */
`timescale 1ns/1ps

module tb_top;
    logic i_mclk;
    logic i_reset_n;
    logic i_sync_reset_n;
    logic i_sample_valid;
    logic [assi_pkg::WORD_W-1:0] tx_word;
    logic sclk, cs_n, din, dout, dout_oe, ready_flag;
    assi_pkg::assi_rx_s rx;
    assi_pkg::assi_stat_s stat;
    logic [assi_pkg::WORD_W-1:0] rx_q[$];
    int miscompares = 0;
    int check_count = 0;
    int n_sync = 0;
    int n_rst = 0;
    int n_abort = 0;
    int n, k;
    int row_len[3] = '{1, 2047, 2048};
    int row_sync[3] = '{1, 1, 0};
    int row_rst[3] = '{0, 0, 1};

    assi_core #(.POR_CYC(20), .TIMEOUT_CYC(1024)) i_assi_core (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_sync_reset_n(i_sync_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_sample_valid(i_sample_valid), .i_tx_word(tx_word),
        .o_dout(dout), .o_dout_oe(dout_oe),
        .o_sample_ready_flag(ready_flag), .o_rx(rx), .o_stat(stat));
    assi_host_model i_assi_host_model (.i_dout(dout), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_din(din));

    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    always @(negedge i_mclk)
    begin
        if (rx.valid === 1'b1)
            rx_q.push_back(rx.data);
        n_sync += int'(stat.sync_pulse === 1'b1);
        n_rst += int'(stat.dev_reset === 1'b1);
        n_abort += int'(stat.frame_abort === 1'b1);
    end

    ////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp)
        begin
            miscompares++;
            $display("unexpected count at %0t: %0d not %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic run_len(input logic lvl, output int cnt);
        cnt = 0;
        while (ready_flag === lvl && cnt < 50)
        begin
            cnt++;
            @(negedge i_mclk);
        end
    endtask : run_len

    task automatic wait_flag(input int lim);
        for (int i = 0; i < lim && ready_flag !== 1'b1; i++)
            @(negedge i_mclk);
    endtask : wait_flag

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////
    initial
    begin
        i_reset_n = 1'b0;
        i_sync_reset_n = 1'b1;
        i_sample_valid = 1'b0;
        tx_word = 24'hA5C3F1;
        repeat (3) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(negedge i_mclk);
        chk_val(ready_flag, 48'h0);
        chk_val(stat.regs_ready, 48'h0);
        chk_val(dout_oe, 48'h0);
        wait_flag(100);
        chk_val(stat.por_done, 48'h1);
        run_len(1'b1, n);
        chk_cnt(n, 4);
        // events span the end of the low phase; set beats clear
        @(posedge i_mclk);
        i_sample_valid <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_sample_valid <= 1'b0;
        wait_flag(20);
        run_len(1'b1, n);
        chk_cnt(n, 4);
        run_len(1'b0, n);
        chk_cnt(n, 4);
        run_len(1'b1, n);
        chk_cnt(n, 4);
        for (int r = 0; r < 3; r++)
        begin
            n_sync = 0;
            n_rst = 0;
            @(posedge i_mclk);
            i_sync_reset_n <= 1'b0;
            repeat (row_len[r]) @(posedge i_mclk);
            i_sync_reset_n <= 1'b1;
            repeat (30) @(posedge i_mclk);
            chk_cnt(n_sync, row_sync[r]);
            chk_cnt(n_rst, row_rst[r]);
        end
        @(negedge i_mclk);
        chk_val(stat.regs_ready, 48'h0);
        for (k = 0; k < 1200 && stat.regs_ready !== 1'b1; k++)
            @(negedge i_mclk);
        chk_cnt(int'(k > 900 && k < 1200), 1);
        i_assi_host_model.frame(8, 48'hF0F0F0F0F0F0, 6000);
        chk_cnt(n_abort, 1);
        chk_cnt(rx_q.size(), 0);
        i_assi_host_model.frame(48, {24'h123456, 24'hFEDCBA}, 0);
        repeat (10) @(negedge i_mclk);
        chk_cnt(rx_q.size(), 2);
        chk_val(rx_q[0], 48'h123456);
        chk_val(rx_q[1], 48'hFEDCBA);
        chk_val(i_assi_host_model.rx_bits, {tx_word, tx_word});
        chk_val(dout_oe, 48'h0);
        chk_cnt(n_abort, 1);
        print_verdict();
    end

    // the whole sequence needs about 40 us
    initial
    begin
        #200000;
        miscompares++;
        $display("unexpected hang at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_top
